//--- logic/dma_data_irq_pkg.sv
// Summary of operation
// - controller drives write lines under grant
// - line 00 is data MSB
// - write line 16 makes odd parity
// - memory checks store parity, returns flag
// - parity optional unless flag is used
// - read data valid during valid strobe
// - read parity valid on later variant only
// - request held low until recognised
// - on recognise drop request, save status
// - eight request and recognise pairs
// - recognise low while fetching trap instruction
// - early variant: status bit 8 zero
// - later variant: status bit 12 one
// - valid strobe low exactly one clock
// - capture write data at store pulse end
// - grant enables controller write drivers
package dma_data_irq_pkg;
  localparam int LINE_W = 17;
  localparam int WORD_W = 16;
  localparam int PAR_POS = 16;
  localparam int CH_N = 8;
  localparam int ST_W = 16;
  localparam int EARLY_MASK_BIT = 8;
  localparam int LATE_ENABLE_BIT = 12;
  localparam int FETCH_LATENCY = 2;
  localparam logic [LINE_W-1:0] LINES_IDLE = 17'h1FFFF;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // bus line 00 is the word's MSB: reverse bit order
  function automatic logic [WORD_W-1:0] lines_to_word(input logic [LINE_W-1:0] l);
    logic [WORD_W-1:0] w;
    w = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      w[WORD_W-1-i] = l[i];
    end
    return w;
  endfunction

  function automatic logic [LINE_W-1:0] word_to_lines(input logic [WORD_W-1:0] w,
                                                     input logic par);
    logic [LINE_W-1:0] l;
    l = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      l[i] = w[WORD_W-1-i];
    end
    l[PAR_POS] = par;
    return l;
  endfunction
endpackage

//--- logic/dma_data_irq_if.sv
`timescale 1ns/1ns
interface dma_data_irq_if;
  import dma_data_irq_pkg::*;
  logic [LINE_W-1:0] writeLines;
  logic writeLinesOe_n;
  logic storePulse_n;
  logic fetchPulse_n;
  logic [LINE_W-1:0] readLines;
  logic readValidStrobe_n;
  logic writeParityFlag_n;
  logic [CH_N-1:0] irqReq_n;
  logic [CH_N-1:0] irqAck_n;

  modport memory_end (
    input writeLines,
    input writeLinesOe_n,
    input storePulse_n,
    input fetchPulse_n,
    output readLines,
    output readValidStrobe_n,
    output writeParityFlag_n,
    input irqReq_n,
    output irqAck_n
  );

  modport ctrl_end (
    output writeLines,
    output writeLinesOe_n,
    output storePulse_n,
    output fetchPulse_n,
    input readLines,
    input readValidStrobe_n,
    input writeParityFlag_n,
    output irqReq_n,
    input irqAck_n
  );
endinterface

//--- logic/dma_memory_end.sv
`timescale 1ns/1ns
module dma_memory_end
  import dma_data_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dma_data_irq_if.memory_end bus,
  input wire logic lateVariant,
  input wire logic [ST_W-1:0] cpuStatus,
  input wire logic higherIrqPending,
  input wire logic trapFetch,
  input wire logic [WORD_W-1:0] memReadWord,
  input wire logic memReadDone,
  output logic [WORD_W-1:0] storeWord,
  output logic storeValid,
  output logic [CH_N-1:0] irqTaken
);
  logic [LINE_W-1:0] readLines_reg, readLines_next;
  logic strobe_reg, strobe_next;
  logic parFlag_reg, parFlag_next;
  logic storeD_reg, storeD_next;
  logic [LINE_W-1:0] capLines_reg, capLines_next;
  logic [WORD_W-1:0] storeWord_reg, storeWord_next;
  logic storeValid_reg, storeValid_next;
  logic [CH_N-1:0] ack_reg, ack_next;
  logic [CH_N-1:0] taken_reg, taken_next;
  logic irqOk;
  logic [CH_N-1:0] grantOne;

  // ----------------------------------------
  // read data and store capture
  // ----------------------------------------
  always_comb
  begin
    readLines_next = readLines_reg;
    strobe_next = 1'b1;
    if (memReadDone)
    begin
      // later variant adds odd parity bit; early leaves it high
      readLines_next = word_to_lines(memReadWord,
        lateVariant ? ~(^memReadWord) : 1'b1);
      strobe_next = 1'b0;
    end
    storeD_next = bus.storePulse_n;
    capLines_next = capLines_reg;
    storeWord_next = storeWord_reg;
    storeValid_next = 1'b0;
    parFlag_next = parFlag_reg;
    // trailing edge of the low store pulse
    if (!bus.storePulse_n)
    begin
      capLines_next = bus.writeLines;
    end
    if (bus.storePulse_n && !storeD_reg)
    begin
      storeWord_next = lines_to_word(capLines_reg);
      storeValid_next = 1'b1;
      parFlag_next = ^capLines_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readLines_reg <= LINES_IDLE;
      strobe_reg <= 1'b1;
      storeD_reg <= 1'b1;
      capLines_reg <= LINES_IDLE;
      storeWord_reg <= WORD_RST;
      storeValid_reg <= 1'b0;
      parFlag_reg <= 1'b1;
    end
    else
    begin
      readLines_reg <= readLines_next;
      strobe_reg <= strobe_next;
      storeD_reg <= storeD_next;
      capLines_reg <= capLines_next;
      storeWord_reg <= storeWord_next;
      storeValid_reg <= storeValid_next;
      parFlag_reg <= parFlag_next;
    end
  end

  // ----------------------------------------
  // interrupt recognition
  // ----------------------------------------
  always_comb
  begin
    irqOk = (lateVariant ? cpuStatus[LATE_ENABLE_BIT]
                         : !cpuStatus[EARLY_MASK_BIT]) && !higherIrqPending;
    grantOne = '0;
    for (int i = CH_N - 1; i >= 0; i--)
    begin
      if (!bus.irqReq_n[i])
      begin
        grantOne = '0;
        grantOne[i] = 1'b1;
      end
    end
    ack_next = '1;
    taken_next = '0;
    if (irqOk && trapFetch && (grantOne != '0))
    begin
      ack_next = ~grantOne;
      taken_next = grantOne;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= '1;
      taken_reg <= '0;
    end
    else
    begin
      ack_reg <= ack_next;
      taken_reg <= taken_next;
    end
  end

  assign bus.readLines = readLines_reg;
  assign bus.readValidStrobe_n = strobe_reg;
  assign bus.writeParityFlag_n = parFlag_reg;
  assign bus.irqAck_n = ack_reg;
  assign storeWord = storeWord_reg;
  assign storeValid = storeValid_reg;
  assign irqTaken = taken_reg;
endmodule

//--- logic/dma_ctrl_end.sv
`timescale 1ns/1ns
module dma_ctrl_end
  import dma_data_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dma_data_irq_if.ctrl_end bus,
  input wire logic [2:0] chanSel,
  input wire logic grant_n,
  input wire logic storeReq,
  input wire logic fetchReq,
  input wire logic [WORD_W-1:0] writeWord,
  input wire logic irqRaise,
  input wire logic [WORD_W-1:0] statusWord,
  output logic [WORD_W-1:0] readWord,
  output logic readValid,
  output logic parityError,
  output logic [WORD_W-1:0] savedStatus,
  output logic statusSaved
);
  logic [LINE_W-1:0] wl_reg, wl_next;
  logic oe_reg, oe_next;
  logic store_reg, store_next;
  logic fetch_reg, fetch_next;
  logic pend_reg, pend_next;
  logic [WORD_W-1:0] rd_reg, rd_next;
  logic rv_reg, rv_next;
  logic pe_reg, pe_next;
  logic storeWait_reg, storeWait_next;
  logic flagDue_reg, flagDue_next;
  logic [CH_N-1:0] req_reg, req_next;
  logic [WORD_W-1:0] st_reg, st_next;
  logic ss_reg, ss_next;

  // ----------------------------------------
  // data path
  // ----------------------------------------
  always_comb
  begin
    wl_next = wl_reg;
    oe_next = grant_n;
    store_next = 1'b1;
    fetch_next = 1'b1;
    if (!grant_n && storeReq)
    begin
      wl_next = word_to_lines(writeWord, ~(^writeWord));
      store_next = 1'b0;
    end
    else if (!grant_n && fetchReq)
    begin
      fetch_next = 1'b0;
    end
    pend_next = pend_reg;
    if (!fetch_reg)
    begin
      pend_next = 1'b1;
    end
    rd_next = rd_reg;
    rv_next = 1'b0;
    if (pend_reg && !bus.readValidStrobe_n)
    begin
      rd_next = lines_to_word(bus.readLines);
      rv_next = 1'b1;
      pend_next = !fetch_reg;
    end
    // flag is registered two cycles after the store pulse: look one cycle later
    storeWait_next = !store_reg;
    flagDue_next = storeWait_reg;
    pe_next = pe_reg;
    if (flagDue_reg && !bus.writeParityFlag_n)
    begin
      pe_next = 1'b1;
    end
    else if (!store_reg)
    begin
      pe_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wl_reg <= LINES_IDLE;
      oe_reg <= 1'b1;
      store_reg <= 1'b1;
      fetch_reg <= 1'b1;
      pend_reg <= 1'b0;
      rd_reg <= WORD_RST;
      rv_reg <= 1'b0;
      pe_reg <= 1'b0;
      storeWait_reg <= 1'b0;
      flagDue_reg <= 1'b0;
    end
    else
    begin
      wl_reg <= wl_next;
      oe_reg <= oe_next;
      store_reg <= store_next;
      fetch_reg <= fetch_next;
      pend_reg <= pend_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
      pe_reg <= pe_next;
      storeWait_reg <= storeWait_next;
      flagDue_reg <= flagDue_next;
    end
  end

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  always_comb
  begin
    req_next = req_reg;
    st_next = st_reg;
    ss_next = 1'b0;
    if (!bus.irqAck_n[chanSel] && !req_reg[chanSel])
    begin
      req_next[chanSel] = 1'b1;
      st_next = statusWord;
      ss_next = 1'b1;
    end
    else if (irqRaise)
    begin
      req_next[chanSel] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_reg <= '1;
      st_reg <= WORD_RST;
      ss_reg <= 1'b0;
    end
    else
    begin
      req_reg <= req_next;
      st_reg <= st_next;
      ss_reg <= ss_next;
    end
  end

  assign bus.writeLines = wl_reg;
  assign bus.writeLinesOe_n = oe_reg;
  assign bus.storePulse_n = store_reg;
  assign bus.fetchPulse_n = fetch_reg;
  assign bus.irqReq_n = req_reg;
  assign readWord = rd_reg;
  assign readValid = rv_reg;
  assign parityError = pe_reg;
  assign savedStatus = st_reg;
  assign statusSaved = ss_reg;
endmodule

//--- tb/dma_data_irq_chk.sv
`timescale 1ns/1ns
module dma_data_irq_chk
  import dma_data_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [LINE_W-1:0] writeLines,
  input wire logic writeLinesOe_n,
  input wire logic storePulse_n,
  input wire logic fetchPulse_n,
  input wire logic [LINE_W-1:0] readLines,
  input wire logic readValidStrobe_n,
  input wire logic writeParityFlag_n,
  input wire logic [CH_N-1:0] irqReq_n,
  input wire logic [CH_N-1:0] irqAck_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire oddW = ^writeLines;
  // ------------------------------
  // wire checks
  // ------------------------------
  sequence storeSeq;
    !storePulse_n ##1 storePulse_n;
  endsequence
  strobe_one_a: assert property ($fell(readValidStrobe_n) |=> readValidStrobe_n)
    else $error("strobe too long");
  pulse_one_a: assert property ($fell(storePulse_n) |=> storePulse_n)
    else $error("store pulse too long");
  write_odd_a: assert property (!storePulse_n |-> oddW)
    else $error("write parity even");
  write_drive_a: assert property (!storePulse_n |-> !writeLinesOe_n)
    else $error("write lines not driven");
  flag_check_a: assert property (storeSeq |=> writeParityFlag_n == $past(oddW, 2))
    else $error("parity flag wrong");
  read_par_a: assert property (!readValidStrobe_n |-> readLines[16] || ^readLines)
    else $error("read parity wrong");
  ack_single_a: assert property ($onehot0(~irqAck_n))
    else $error("several acks");
  for (genvar k = 0; k < CH_N; k++)
  begin
    req_hold_a: assert property (!irqReq_n[k] && irqAck_n[k] |=> !irqReq_n[k])
      else $error("request dropped early");
    req_drop_a: assert property (!irqAck_n[k] && !irqReq_n[k] |=> irqReq_n[k])
      else $error("request kept after ack");
    ack_cause_a: assert property ($fell(irqAck_n[k]) |-> !$past(irqReq_n[k]))
      else $error("ack without request");
  end
endmodule

//--- tb/dma_bus_data_and_interrupt_lines_tb.sv
`timescale 1ns/1ns
module dma_bus_data_and_interrupt_lines_tb;
  import dma_data_irq_pkg::*;
  logic clk, rst_n, lateVariant, higherIrqPending, trapFetch, memReadDone;
  logic grant_n, storeReq, fetchReq, irqRaise, storeValid, readValid, parityError, statusSaved;
  logic [ST_W-1:0] cpuStatus;
  logic [WORD_W-1:0] memReadWord, writeWord, statusWord, storeWord, readWord, savedStatus;
  logic [2:0] chanSel;
  logic [CH_N-1:0] irqTaken;
  int miscompares = 0;
  int checked = 0;
  dma_data_irq_if bus ();
  dma_memory_end dma_memory_end_i (.clk(clk), .rst_n(rst_n), .bus(bus),
    .lateVariant(lateVariant), .cpuStatus(cpuStatus), .higherIrqPending(higherIrqPending),
    .trapFetch(trapFetch), .memReadWord(memReadWord), .memReadDone(memReadDone),
    .storeWord(storeWord), .storeValid(storeValid), .irqTaken(irqTaken));
  dma_ctrl_end dma_ctrl_end_i (.clk(clk), .rst_n(rst_n), .bus(bus), .chanSel(chanSel),
    .grant_n(grant_n), .storeReq(storeReq), .fetchReq(fetchReq), .writeWord(writeWord),
    .irqRaise(irqRaise), .statusWord(statusWord), .readWord(readWord), .readValid(readValid),
    .parityError(parityError), .savedStatus(savedStatus), .statusSaved(statusSaved));
  dma_data_irq_chk dma_data_irq_chk_i (.clk(clk), .rst_n(rst_n), .writeLines(bus.writeLines),
    .writeLinesOe_n(bus.writeLinesOe_n), .storePulse_n(bus.storePulse_n),
    .fetchPulse_n(bus.fetchPulse_n), .readLines(bus.readLines),
    .readValidStrobe_n(bus.readValidStrobe_n), .writeParityFlag_n(bus.writeParityFlag_n),
    .irqReq_n(bus.irqReq_n), .irqAck_n(bus.irqAck_n));
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input string name, input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic await(ref logic s, input logic v);
    int n;
    n = 0;
    #1;
    while (n < 20 && s !== v)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wait", s, v);
  endtask
  task automatic t_store(input logic [WORD_W-1:0] w);
    @(posedge clk);
    grant_n <= 1'b0;
    writeWord <= w;
    storeReq <= 1'b1;
    @(posedge clk);
    storeReq <= 1'b0;
    await(bus.storePulse_n, 1'b0);
    chk("line0", bus.writeLines[0], w[15]);
    chk("line15", bus.writeLines[15], w[0]);
    await(storeValid, 1'b1);
    chk("storeWord", storeWord, w);
    @(posedge clk);
    #1;
    chk("parityError", parityError, 1'b0);
    @(posedge clk);
    grant_n <= 1'b1;
    $display("store %h done", w);
  endtask
  task automatic t_fetch(input logic [WORD_W-1:0] w, input logic late);
    logic hit;
    hit = 1'b0;
    @(posedge clk);
    lateVariant <= late;
    memReadWord <= ~w;
    memReadDone <= 1'b1;
    @(posedge clk);
    memReadDone <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      hit |= readValid;
    end
    chk("stray", hit, 1'b0);
    grant_n <= 1'b0;
    fetchReq <= 1'b1;
    @(posedge clk);
    fetchReq <= 1'b0;
    grant_n <= 1'b1;
    memReadWord <= w;
    memReadDone <= 1'b1;
    @(posedge clk);
    memReadDone <= 1'b0;
    await(bus.readValidStrobe_n, 1'b0);
    chk("rpar", bus.readLines[16], late ? ~^w : 1'b1);
    chk("rline15", bus.readLines[15], w[0]);
    await(readValid, 1'b1);
    chk("readWord", readWord, w);
    $display("fetch %h done", w);
  endtask
  task automatic t_irq(input int ch, input logic late);
    logic [ST_W-1:0] good;
    logic [CH_N-1:0] tk;
    logic hit;
    good = late ? 16'h1000 : 16'hFEFF;
    @(posedge clk);
    chanSel <= ch[2:0];
    lateVariant <= late;
    statusWord <= 16'hA500 | 16'(ch);
    irqRaise <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      cpuStatus <= (p == 0) ? ~good : good;
      higherIrqPending <= (p == 1);
      trapFetch <= (p != 2);
      hit = 1'b0;
      tk = '0;
      repeat (6)
      begin
        @(posedge clk);
        irqRaise <= 1'b0;
        hit |= statusSaved;
        tk |= irqTaken;
      end
      chk("ackTaken", {hit, tk}, (p == 3) ? {1'b1, 8'h01 << ch} : 9'h000);
    end
    chk("savedStatus", savedStatus, 16'hA500 | 16'(ch));
    $display("irq channel %0d done", ch);
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------
  // main
  // ------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #40000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    {lateVariant, higherIrqPending, trapFetch, memReadDone} = '0;
    {storeReq, fetchReq, irqRaise} = '0;
    grant_n = 1'b1;
    {cpuStatus, memReadWord, writeWord, statusWord} = '0;
    chanSel = 3'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_store(16'h8000);
    t_store(16'h0001);
    t_store(16'hA5C3);
    t_fetch(16'h8001, 1'b0);
    t_fetch(16'h7FFE, 1'b1);
    for (int c = 0; c < CH_N; c++) t_irq(c, c[0]);
    print_verdict();
  end
endmodule
